// file: rtl/eee_lpi_ctrl.sv
// Top: EEE low power idle control registers, timers and interrupt
module eee_lpi_ctrl #(
  parameter int NPORTS = 3,
  parameter int UW = 16,
  parameter int IDLE_UNIT = eee_pkg::IDLE_UNIT_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic page_rx,
  input wire logic partner_an_able,
  input wire logic [NPORTS-1:0] queue_empty,
  input wire logic [NPORTS*UW-1:0] buffer_usage,
  input wire logic p2_lpi_exit,
  output logic p1_np_en,
  output logic p2_np_en,
  output logic lpi_request,
  output logic lpi_terminate,
  output logic p2_tx_hold,
  output logic irq
);
  logic [7:0] recovery;
  logic [7:0] np_ctrl;
  logic [15:0] idle_wait;
  logic [7:0] load_thresh;
  logic eee_en;
  logic page_flag;
  logic partner_an;
  logic [3:0] int_status;
  logic [3:0] int_mask;
  logic [3:0] events;
  logic [NPORTS-1:0] over;
  logic [NPORTS-1:0] idle_done;
  logic any_over;
  logic all_idle;
  logic rec_run;
  logic rec_done;
  logic status_rd;
  logic next_lpi_request;
  logic [15:0] next_rdata;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      recovery <= eee_pkg::RST_RECOVERY;
      np_ctrl <= eee_pkg::RST_NP_CTRL;
      idle_wait <= eee_pkg::RST_IDLE_WAIT;
      load_thresh <= eee_pkg::RST_LOAD_THRESH;
      eee_en <= 1'b1;
      int_mask <= 4'h0;
    end else if (wr) begin
      unique case (addr)
        eee_pkg::OFF_RECOVERY: recovery <= wdata[7:0];
        eee_pkg::OFF_NP_CTRL: np_ctrl <= {wdata[7:6], 4'h0, wdata[1:0]};
        eee_pkg::OFF_IDLE_WAIT: idle_wait <= wdata;
        eee_pkg::OFF_LOAD_THRESH: load_thresh <= wdata[7:0];
        eee_pkg::OFF_INT_MASK: int_mask <= wdata[3:0];
        eee_pkg::OFF_EEE_CTRL: eee_en <= wdata[eee_pkg::BIT_EEE_EN];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      p1_np_en <= 1'b0;
      p2_np_en <= 1'b1;
    end else begin
      p2_np_en <= np_ctrl[eee_pkg::BIT_P2_NP_EN];
      p1_np_en <= np_ctrl[eee_pkg::BIT_P1_NP_EN];
    end
  end

  assign status_rd = rd && (addr == eee_pkg::OFF_NEG_STATUS);

  // Set wins over the read-clear so a page in the read cycle is kept
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      page_flag <= 1'b0;
      partner_an <= 1'b0;
    end else begin
      partner_an <= partner_an_able;
      if (page_rx) begin
        page_flag <= 1'b1;
      end else if (status_rd) begin
        page_flag <= 1'b0;
      end
    end
  end

  for (genvar i = 0; i < NPORTS; i++) begin : g_port
    eee_unit_timer #(.UNIT_CYC(IDLE_UNIT), .CW(16)) u_idle (
      .mclk(mclk),
      .resetn(resetn),
      .run(eee_en && queue_empty[i]),
      .limit(idle_wait),
      .expired(idle_done[i])
    );
    eee_load_cmp #(.UW(UW)) u_cmp (
      .usage(buffer_usage[i*UW +: UW]),
      .thresh(load_thresh),
      .over(over[i])
    );
  end

  assign all_idle = &idle_done;
  assign any_over = |over;
  // Timer clears on any traffic, so a lone empty port does not request idle
  assign next_lpi_request = eee_en && all_idle && !any_over;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      lpi_request <= 1'b0;
      lpi_terminate <= 1'b0;
    end else begin
      lpi_request <= next_lpi_request;
      lpi_terminate <= any_over;
    end
  end

  eee_unit_timer #(.UNIT_CYC(eee_pkg::RECOVERY_UNIT_CYC), .CW(8)) u_recover (
    .mclk(mclk),
    .resetn(resetn),
    .run(rec_run),
    .limit(recovery),
    .expired(rec_done)
  );

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rec_run <= 1'b0;
      p2_tx_hold <= 1'b0;
    end else if (p2_lpi_exit) begin
      rec_run <= 1'b1;
      p2_tx_hold <= 1'b1;
    end else if (rec_done) begin
      rec_run <= 1'b0;
      p2_tx_hold <= 1'b0;
    end
  end

  assign events = {rec_done, any_over && !lpi_terminate, next_lpi_request && !lpi_request,
                   page_rx};

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      int_status <= 4'h0;
    end else begin
      int_status <= events | ((rd && addr == eee_pkg::OFF_INT_STATUS) ? 4'h0 : int_status);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status & int_mask);
    end
  end

  always_comb begin
    next_rdata = 16'h0;
    unique case (addr)
      eee_pkg::OFF_NEG_STATUS: begin
        next_rdata = eee_pkg::RST_NEG_STATUS_HI;
        next_rdata[eee_pkg::BIT_NP_ABLE] = 1'b1;
        next_rdata[eee_pkg::BIT_PAGE_RX] = page_flag;
        next_rdata[eee_pkg::BIT_PARTNER_AN] = partner_an;
      end
      eee_pkg::OFF_RECOVERY: next_rdata = {8'h00, recovery};
      eee_pkg::OFF_NP_CTRL: next_rdata = {8'h00, np_ctrl};
      eee_pkg::OFF_IDLE_WAIT: next_rdata = idle_wait;
      eee_pkg::OFF_LOAD_THRESH: next_rdata = {8'h00, load_thresh};
      eee_pkg::OFF_INT_STATUS: next_rdata = {12'h000, int_status};
      eee_pkg::OFF_INT_MASK: next_rdata = {12'h000, int_mask};
      eee_pkg::OFF_EEE_CTRL: next_rdata = {15'h0000, eee_en};
      default: next_rdata = 16'h0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata <= 16'h0;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 16'h0;
    end
  end

  property p_np_able;
    @(posedge mclk) disable iff (!resetn)
    rd && addr == eee_pkg::OFF_NEG_STATUS |=> rdata[2];
  endproperty
  a_np_able: assert property (p_np_able) else $error("next page able not read as one");

  property p_page_latch;
    @(posedge mclk) disable iff (!resetn)
    page_rx |=> page_flag;
  endproperty
  a_page_latch: assert property (p_page_latch) else $error("page flag not latched");

  property p_page_clear;
    @(posedge mclk) disable iff (!resetn)
    status_rd && !page_rx |=> !page_flag;
  endproperty
  a_page_clear: assert property (p_page_clear) else $error("page flag not cleared");

  property p_partner;
    @(posedge mclk) disable iff (!resetn)
    partner_an_able |=> partner_an;
  endproperty
  a_partner: assert property (p_partner) else $error("partner ability not shown");

  property p_hold_start;
    @(posedge mclk) disable iff (!resetn)
    p2_lpi_exit && recovery != 8'h00 |=> p2_tx_hold [*8];
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("transmit hold too short");

  property p_np_follow;
    @(posedge mclk) disable iff (!resetn)
    ##1 (p2_np_en == $past(np_ctrl[1])) && (p1_np_en == $past(np_ctrl[0]));
  endproperty
  a_np_follow: assert property (p_np_follow) else $error("next page enable mismatch");

  property p_req_eee;
    @(posedge mclk) disable iff (!resetn)
    lpi_request |-> $past(eee_en);
  endproperty
  a_req_eee: assert property (p_req_eee) else $error("idle request without EEE");

  property p_terminate;
    @(posedge mclk) disable iff (!resetn)
    any_over |=> lpi_terminate && !lpi_request;
  endproperty
  a_terminate: assert property (p_terminate) else $error("load did not end idle");

  property p_req_all;
    @(posedge mclk) disable iff (!resetn)
    lpi_request |-> $past(&queue_empty);
  endproperty
  a_req_all: assert property (p_req_all) else $error("request with busy queue");

  property p_hold_keep;
    @(posedge mclk) disable iff (!resetn)
    p2_tx_hold && !rec_done |=> p2_tx_hold;
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("hold ended early");

  property p_hold_end;
    @(posedge mclk) disable iff (!resetn)
    rec_done && !p2_lpi_exit |=> !p2_tx_hold;
  endproperty
  a_hold_end: assert property (p_hold_end) else $error("hold not released");

  property p_hold_event;
    @(posedge mclk) disable iff (!resetn)
    rec_done |=> int_status[eee_pkg::INT_RECOVERED];
  endproperty
  a_hold_event: assert property (p_hold_event) else $error("recovery not flagged");

  property p_page_event;
    @(posedge mclk) disable iff (!resetn)
    page_rx |=> int_status[eee_pkg::INT_PAGE_RX];
  endproperty
  a_page_event: assert property (p_page_event) else $error("page not flagged");

  property p_req_event;
    @(posedge mclk) disable iff (!resetn)
    next_lpi_request && !lpi_request |=> int_status[eee_pkg::INT_LPI_REQ];
  endproperty
  a_req_event: assert property (p_req_event) else $error("request not flagged");

  property p_req_off;
    @(posedge mclk) disable iff (!resetn)
    !eee_en |=> !lpi_request;
  endproperty
  a_req_off: assert property (p_req_off) else $error("request with EEE off");

  property p_term_req;
    @(posedge mclk) disable iff (!resetn)
    lpi_terminate |-> !lpi_request;
  endproperty
  a_term_req: assert property (p_term_req) else $error("request during load");

  property p_load_event;
    @(posedge mclk) disable iff (!resetn)
    any_over && !lpi_terminate |=> int_status[eee_pkg::INT_LOAD_EXIT];
  endproperty
  a_load_event: assert property (p_load_event) else $error("load not flagged");

  c_page: cover property (@(posedge mclk) disable iff (!resetn) page_rx ##1 status_rd);
  c_req: cover property (@(posedge mclk) disable iff (!resetn) $rose(lpi_request));
  c_hold: cover property (@(posedge mclk) disable iff (!resetn) $fell(p2_tx_hold));
  c_irq: cover property (@(posedge mclk) disable iff (!resetn) $rose(irq));
  c_term: cover property (@(posedge mclk) disable iff (!resetn) $rose(lpi_terminate));
endmodule

// file: rtl/eee_pkg.sv
// Package: register map, field positions, reset values and timing counts
package eee_pkg;
  localparam logic [7:0] OFF_NEG_STATUS = 8'hf0;
  localparam logic [7:0] OFF_RECOVERY = 8'hf2;
  localparam logic [7:0] OFF_NP_CTRL = 8'hf3;
  localparam logic [7:0] OFF_IDLE_WAIT = 8'hf4;
  localparam logic [7:0] OFF_LOAD_THRESH = 8'hf6;
  localparam logic [7:0] OFF_INT_STATUS = 8'hf8;
  localparam logic [7:0] OFF_INT_MASK = 8'hfa;
  localparam logic [7:0] OFF_EEE_CTRL = 8'hfc;
  localparam int BIT_NP_ABLE = 2;
  localparam int BIT_PAGE_RX = 1;
  localparam int BIT_PARTNER_AN = 0;
  localparam int BIT_P2_NP_EN = 1;
  localparam int BIT_P1_NP_EN = 0;
  localparam int BIT_EEE_EN = 0;
  localparam int INT_PAGE_RX = 0;
  localparam int INT_LPI_REQ = 1;
  localparam int INT_LOAD_EXIT = 2;
  localparam int INT_RECOVERED = 3;
  localparam logic [7:0] RST_RECOVERY = 8'h27;
  localparam logic [15:0] RST_IDLE_WAIT = 16'h03e8;
  localparam logic [7:0] RST_LOAD_THRESH = 8'h04;
  localparam logic [7:0] RST_NP_CTRL = 8'h02;
  localparam logic [15:0] RST_NEG_STATUS_HI = 16'h8060;
  localparam int CLK_PERIOD_PS = 25000;
  localparam int RECOVERY_UNIT_PS = 640000;
  localparam int IDLE_UNIT_NS = 1300000;
  // Rounded up so the transmit hold never falls short of the programmed time
  localparam int RECOVERY_UNIT_CYC = (RECOVERY_UNIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int IDLE_UNIT_CYC = IDLE_UNIT_NS / (CLK_PERIOD_PS / 1000);
  localparam int LOAD_UNIT_BYTES = 128;
endpackage

// file: rtl/eee_unit_timer.sv
// Unit timer: counts whole units of a base tick against a programmed limit
module eee_unit_timer #(
  parameter int UNIT_CYC = 26,
  parameter int CW = 16
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic run,
  input wire logic [CW-1:0] limit,
  output logic expired
);
  logic [31:0] tick;
  logic [CW-1:0] units;
  logic unit_done;

  assign unit_done = (tick == 32'(UNIT_CYC - 1));

  always_ff @(posedge mclk) begin
    if (!resetn || !run) begin
      tick <= 32'h0;
      units <= '0;
    end else if (unit_done) begin
      tick <= 32'h0;
      if (units != limit) begin
        units <= units + 1'b1;
      end
    end else if (units != limit) begin
      tick <= tick + 32'h1;
    end
  end

  // Limit reached means the full programmed span has elapsed
  assign expired = run && (units == limit);
endmodule

// file: rtl/eee_load_cmp.sv
// Load comparator: one port's buffer usage against the shared threshold
module eee_load_cmp #(
  parameter int UW = 16
) (
  input wire logic [UW-1:0] usage,
  input wire logic [7:0] thresh,
  output logic over
);
  localparam int SHIFT = $clog2(eee_pkg::LOAD_UNIT_BYTES);
  logic [UW+SHIFT-1:0] limit_bytes;

  assign limit_bytes = {{(UW - 8){1'b0}}, thresh, {SHIFT{1'b0}}};
  assign over = {{SHIFT{1'b0}}, usage} > limit_bytes;
endmodule

// file: verification/eee_partner_model.sv
// Link partner model: sends negotiation pages and reports auto-negotiation ability
module eee_partner_model (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic send_page,
  input wire logic an_cmd,
  output logic page_rx,
  output logic partner_an_able
);
  timeunit 1ns;
  timeprecision 100ps;
  // One page per command cycle; the partner never repeats a page on its own
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      page_rx <= 1'b0;
      partner_an_able <= 1'b0;
    end else begin
      page_rx <= send_page;
      partner_an_able <= an_cmd;
    end
  end
endmodule

// file: verification/tb_top.sv
// Testbench: register map, page flag, interrupt, recovery, idle and load checks
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic send_page = 1'b0;
  logic an_cmd = 1'b0;
  logic [2:0] queue_empty = 3'h0;
  logic [47:0] buffer_usage = 48'h0;
  logic [47:0] u;
  logic p2_lpi_exit = 1'b0;
  logic [15:0] rdata, rv;
  logic [15:0] lf = 16'h0046;
  logic page_rx, partner_an_able, p1_np_en, p2_np_en, lpi_request, lpi_terminate, p2_tx_hold, irq;
  int failures = 0;
  int cmp_count = 0;
  int n;
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  eee_lpi_ctrl #(.NPORTS(3), .UW(16), .IDLE_UNIT(4)) eee_lpi_ctrl_inst (
    .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .page_rx(page_rx), .partner_an_able(partner_an_able),
    .queue_empty(queue_empty), .buffer_usage(buffer_usage), .p2_lpi_exit(p2_lpi_exit),
    .p1_np_en(p1_np_en), .p2_np_en(p2_np_en), .lpi_request(lpi_request),
    .lpi_terminate(lpi_terminate), .p2_tx_hold(p2_tx_hold), .irq(irq));
  eee_partner_model eee_partner_model_inst (.mclk(mclk), .resetn(resetn),
    .send_page(send_page), .an_cmd(an_cmd), .page_rx(page_rx),
    .partner_an_able(partner_an_able));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task rreg(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task pulse_page;
    send_page <= 1'b1;
    cyc(1);
    send_page <= 1'b0;
    cyc(4);
  endtask
  task conclude;
    $display("counts: %0d compared, %0d failed", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #300000;
    failures++;
    conclude();
  end
  initial begin
    cyc(20);
    resetn <= 1'b1;
    cyc(1);
    rreg(8'hf0); check("status", rv, 16'h8064);
    rreg(8'hf2); check("recovery", rv, 16'h0027);
    rreg(8'hf3); check("np_ctrl", rv, 16'h0002);
    rreg(8'hf4); check("idle_wait", rv, 16'h03e8);
    rreg(8'hf6); check("thresh", rv, 16'h0004);
    rreg(8'h10); check("unmapped", rv, 16'h0000);
    rreg(8'hfc); check("eee_ctrl", rv, 16'h0001);
    rreg(8'hf8); check("int_status", rv, 16'h0000);
    check("np_en", {14'h0, p2_np_en, p1_np_en}, 16'h0002);
    $display("test reset done");
    wreg(8'hfa, 16'h0001);
    an_cmd <= 1'b1;
    pulse_page();
    check("irq", {15'h0, irq}, 16'h0001);
    rreg(8'hf0); check("status", rv, 16'h8067);
    rreg(8'hf0); check("status", rv, 16'h8065);
    rreg(8'hf8); check("int_status", rv, 16'h0001);
    cyc(3);
    check("irq", {15'h0, irq}, 16'h0000);
    wreg(8'hfa, 16'h0000);
    pulse_page();
    check("irq", {15'h0, irq}, 16'h0000);
    rreg(8'hf8); check("int_status", rv, 16'h0001);
    an_cmd <= 1'b0;
    cyc(2);
    rreg(8'hf0); check("status", rv, 16'h8066);
    $display("test page done");
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      wreg(8'hf3, lf);
      cyc(2);
      rreg(8'hf3); check("np_ctrl", rv, lf & 16'h00c3);
      check("np_en", {14'h0, p2_np_en, p1_np_en}, {14'h0, lf[1:0]});
    end
    wreg(8'hf3, 16'hffff);
    cyc(2);
    rreg(8'hf3); check("np_ctrl", rv, 16'h00c3);
    check("np_en", {14'h0, p2_np_en, p1_np_en}, 16'h0003);
    wreg(8'hf3, 16'h0002);
    $display("test np done");
    wreg(8'hf2, 16'h0003);
    p2_lpi_exit <= 1'b1;
    cyc(1);
    p2_lpi_exit <= 1'b0;
    check("hold", {15'h0, p2_tx_hold}, 16'h0001);
    n = 0;
    while (p2_tx_hold === 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    check("hold_len", 16'(n >= 78 && n <= 80), 16'h0001);
    wreg(8'hf2, 16'h0000);
    p2_lpi_exit <= 1'b1;
    cyc(1);
    p2_lpi_exit <= 1'b0;
    check("hold0", {15'h0, p2_tx_hold}, 16'h0001);
    cyc(1);
    check("hold0_end", {15'h0, p2_tx_hold}, 16'h0000);
    rreg(8'hf8); check("int_status", rv, 16'h0008);
    $display("test recovery done");
    wreg(8'hf4, 16'h0005);
    queue_empty <= 3'h7;
    n = 0;
    while (lpi_request !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    check("idle_len", 16'(n >= 20 && n <= 23), 16'h0001);
    queue_empty[1] <= 1'b0;
    cyc(3);
    check("lpi_req", {15'h0, lpi_request}, 16'h0000);
    wreg(8'hfc, 16'h0000);
    queue_empty <= 3'h7;
    cyc(60);
    check("lpi_req", {15'h0, lpi_request}, 16'h0000);
    wreg(8'hfc, 16'h0001);
    queue_empty <= 3'h0;
    $display("test idle done");
    wreg(8'hf6, 16'h0002);
    for (int p = 0; p < 3; p++) begin
      lf = lfsr(lf);
      u = {3{8'h00, lf[7:0]}};
      u[p*16+:16] = 16'd256;
      buffer_usage <= u;
      cyc(3);
      check("terminate", {15'h0, lpi_terminate}, 16'h0000);
      u[p*16+:16] = 16'd257;
      buffer_usage <= u;
      cyc(3);
      check("terminate", {15'h0, lpi_terminate}, 16'h0001);
    end
    rreg(8'hf8); check("int_status", rv, 16'h0006);
    $display("test load done");
    conclude();
  end
endmodule
